// [smk_consts.svh]
`ifndef SMK_CONSTS_SVH
`define SMK_CONSTS_SVH

// System clock
`define SMK_CLK_PERIOD_NS   4
`define SMK_CLK_HZ          250000000

// Base tick and derived intervals, counted in ticks
`define SMK_SEC_NS          1000000000
`define SMK_TICK_NS         500000
`define SMK_TICK_CYCLES     (`SMK_TICK_NS / `SMK_CLK_PERIOD_NS)
`define SMK_TICKS_PER_SEC   (`SMK_SEC_NS / `SMK_TICK_NS)
`define SMK_BLINK_PERIOD_S  1
`define SMK_TEST_S          3
`define SMK_EMIT_PERIOD_S   10

// Emitter settle time before the photo conversion starts
`define SMK_SETTLE_NS       1000
`define SMK_SETTLE_CYCLES   ((`SMK_SETTLE_NS + `SMK_CLK_PERIOD_NS - 1) / `SMK_CLK_PERIOD_NS)

// SPI clock limit and half period in system clocks, rounded up
`define SMK_SPI_MAX_HZ      4000000
`define SMK_SPI_HALF        ((`SMK_CLK_HZ + 2 * `SMK_SPI_MAX_HZ - 1) / (2 * `SMK_SPI_MAX_HZ))
`define SMK_SPI_BITS        16
`define SMK_SPI_WRITE       1'b1
`define SMK_SPI_READ        1'b0

// Front-end register map
`define SMK_REG_COUNT       31
`define SMK_REG_LED_CURRENT 5'h0a
`define SMK_REG_BATT_LOAD   5'h0b
`define SMK_REG_BATT_CURR   5'h0c
`define SMK_BATT_LOAD_ON    8'h01
`define SMK_BATT_LOAD_OFF   8'h00

// Measurement and boost regulation
`define SMK_SMOKE_THRESH    10'h180
`define SMK_BOOST_TARGET    10'h200
`define SMK_DUTY_MAX        8'hc0

`endif

// [smk_pkg.sv]
package smk_pkg;
  typedef enum logic [1:0] {SMK_AL_IDLE, SMK_AL_TEST, SMK_AL_SMOKE} smk_alarm_t;
  typedef enum logic [1:0] {SMK_MS_IDLE, SMK_MS_SETTLE, SMK_MS_PHOTO, SMK_MS_BOOST} smk_meas_t;
  typedef enum logic [2:0] {SMK_SQ_LED, SMK_SQ_IDLE, SMK_SQ_LOAD_ON, SMK_SQ_READ,
                            SMK_SQ_LOAD_OFF} smk_seq_t;
  typedef enum logic {SMK_SP_IDLE, SMK_SP_SHIFT} smk_spi_st_t;
endpackage

// [smk_spi_if.sv]
interface smk_spi_if;
  logic       start;
  logic       rw;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic       busy;
  logic       done;
  logic [7:0] rdata;
  modport master (output start, output rw, output addr, output wdata,
                  input busy, input done, input rdata);
  modport engine (input start, input rw, input addr, input wdata,
                  output busy, output done, output rdata);
endinterface

// [smk_spi_engine.sv]
`include "smk_consts.svh"

module smk_spi_engine
  import smk_pkg::*;
(
  // Clock and reset
  input  wire logic   mclk,
  input  wire logic   reset,
  // Transfer request
  smk_spi_if.engine   req,
  // Front-end pins
  output logic        spi_sck,
  output logic        spi_mosi,
  output logic        spi_sen_n,
  input  wire logic   spi_miso
);
  smk_spi_st_t state, next_state;
  logic [5:0]  div, next_div;
  logic [3:0]  bitn, next_bitn;
  logic [15:0] shreg, next_shreg;
  logic [15:0] rx, next_rx;
  logic        next_sck, next_mosi, next_sen_n, next_busy, next_done;
  logic [7:0]  next_rdata;

  // Mode 0 shifter, MSB first, SCK held under the front-end limit
  always_comb begin
    next_state  = state;
    next_div    = div;
    next_bitn   = bitn;
    next_shreg  = shreg;
    next_rx     = rx;
    next_sck    = spi_sck;
    next_mosi   = spi_mosi;
    next_sen_n  = spi_sen_n;
    next_done   = 1'b0;
    next_rdata  = req.rdata;
    case (state)
      SMK_SP_IDLE: begin
        if (req.start) begin
          next_shreg = {req.rw, req.addr, 2'b00, req.wdata};
          next_mosi  = req.rw;
          next_sen_n = 1'b0;
          next_div   = 6'h00;
          next_bitn  = 4'h0;
          next_state = SMK_SP_SHIFT;
        end
      end
      default: begin
        next_div = div + 6'h01;
        if (div == 6'(`SMK_SPI_HALF - 1)) begin
          next_div = 6'h00;
          if (!spi_sck) begin
            next_sck = 1'b1;
            next_rx  = {rx[14:0], spi_miso};
          end else begin
            next_sck = 1'b0;
            if (bitn == 4'(`SMK_SPI_BITS - 1)) begin
              next_sen_n = 1'b1;
              next_done  = 1'b1;
              next_rdata = rx[7:0];
              next_state = SMK_SP_IDLE;
            end else begin
              next_bitn  = bitn + 4'h1;
              next_shreg = {shreg[14:0], 1'b0};
              next_mosi  = shreg[14];
            end
          end
        end
      end
    endcase
    next_busy = (next_state != SMK_SP_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state     <= SMK_SP_IDLE;
      div       <= 6'h00;
      bitn      <= 4'h0;
      shreg     <= 16'h0000;
      rx        <= 16'h0000;
      spi_sck   <= 1'b0;
      spi_mosi  <= 1'b0;
      spi_sen_n <= 1'b1;
      req.busy  <= 1'b0;
      req.done  <= 1'b0;
      req.rdata <= 8'h00;
    end else begin
      state     <= next_state;
      div       <= next_div;
      bitn      <= next_bitn;
      shreg     <= next_shreg;
      rx        <= next_rx;
      spi_sck   <= next_sck;
      spi_mosi  <= next_mosi;
      spi_sen_n <= next_sen_n;
      req.busy  <= next_busy;
      req.done  <= next_done;
      req.rdata <= next_rdata;
    end
  end
endmodule

// [smk_seq.sv]
`include "smk_consts.svh"

module smk_seq
  import smk_pkg::*;
#(
  parameter int TICK_CYCLES = `SMK_TICK_CYCLES
)(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // Board inputs
  input  wire logic       test_button,
  input  wire logic       supply_is_9v,
  input  wire logic [7:0] led_current_code,
  input  wire logic       led_code_update,
  input  wire logic       batt_test_req,
  // Converter
  output logic            adc_start,
  output logic            adc_sel_boost,
  input  wire logic       adc_done,
  input  wire logic [9:0] adc_data,
  // Indicators, horn, emitter, boost
  output logic            alarm_indicator,
  output logic            presence_indicator,
  output logic            horn_enable,
  output logic            emitter_enable,
  output logic            boost_enable,
  output logic            boost_bypass,
  output logic            boost_pwm,
  // Status
  output logic            smoke_alarm,
  output logic [9:0]      photo_reading,
  output logic [7:0]      battery_reading,
  output logic            battery_valid,
  // Front-end SPI
  output logic            spi_sck,
  output logic            spi_mosi,
  output logic            spi_sen_n,
  input  wire logic       spi_miso
);
  smk_spi_if spi ();

  // Time base
  logic [16:0] presc, next_presc;
  logic        tick, next_tick;
  logic [15:0] blink_cnt, next_blink_cnt, emit_cnt, next_emit_cnt;
  logic        emit_evt, next_emit_evt, next_presence;

  // All long intervals hang off one 500 us tick
  always_comb begin
    next_presc     = presc + 17'h00001;
    next_tick      = 1'b0;
    next_blink_cnt = blink_cnt;
    next_emit_cnt  = emit_cnt;
    next_emit_evt  = 1'b0;
    next_presence  = presence_indicator;
    if (presc == 17'(TICK_CYCLES - 1)) begin
      next_presc = 17'h00000;
      next_tick  = 1'b1;
    end
    if (tick) begin
      next_blink_cnt = blink_cnt + 16'h0001;
      if (blink_cnt == 16'(`SMK_TICKS_PER_SEC * `SMK_BLINK_PERIOD_S / 2 - 1)) begin
        next_blink_cnt = 16'h0000;
        next_presence  = ~presence_indicator;
      end
      next_emit_cnt = emit_cnt + 16'h0001;
      if (emit_cnt == 16'(`SMK_TICKS_PER_SEC * `SMK_EMIT_PERIOD_S - 1)) begin
        next_emit_cnt = 16'h0000;
        next_emit_evt = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      presc              <= 17'h00000;
      tick               <= 1'b0;
      blink_cnt          <= 16'h0000;
      emit_cnt           <= 16'h0000;
      emit_evt           <= 1'b0;
      presence_indicator <= 1'b0;
    end else begin
      presc              <= next_presc;
      tick               <= next_tick;
      blink_cnt          <= next_blink_cnt;
      emit_cnt           <= next_emit_cnt;
      emit_evt           <= next_emit_evt;
      presence_indicator <= next_presence;
    end
  end

  // Alarm sequencing
  smk_alarm_t al, next_al;
  logic [15:0] test_cnt, next_test_cnt;
  logic        btn_q, press, smoke_seen, next_horn;

  assign press = test_button & ~btn_q;

  // Smoke outranks a running horn test
  always_comb begin
    next_al       = al;
    next_test_cnt = test_cnt;
    case (al)
      SMK_AL_IDLE: begin
        if (smoke_seen) begin
          next_al = SMK_AL_SMOKE;
        end else if (press) begin
          next_al       = SMK_AL_TEST;
          next_test_cnt = 16'h0000;
        end
      end
      SMK_AL_TEST: begin
        if (tick) next_test_cnt = test_cnt + 16'h0001;
        if (smoke_seen) begin
          next_al = SMK_AL_SMOKE;
        end else if (tick && test_cnt == 16'(`SMK_TICKS_PER_SEC * `SMK_TEST_S - 1)) begin
          next_al = SMK_AL_IDLE;
        end
      end
      default: begin
        if (press) next_al = SMK_AL_IDLE;
      end
    endcase
    next_horn = (next_al != SMK_AL_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      al              <= SMK_AL_IDLE;
      test_cnt        <= 16'h0000;
      btn_q           <= 1'b0;
      horn_enable     <= 1'b0;
      alarm_indicator <= 1'b0;
      smoke_alarm     <= 1'b0;
      boost_enable    <= 1'b0;
      boost_bypass    <= 1'b0;
    end else begin
      al              <= next_al;
      test_cnt        <= next_test_cnt;
      btn_q           <= test_button;
      horn_enable     <= next_horn;
      alarm_indicator <= next_horn;
      smoke_alarm     <= (next_al == SMK_AL_SMOKE);
      boost_enable    <= next_horn & ~supply_is_9v;
      boost_bypass    <= supply_is_9v;
    end
  end

  // Shared converter: emitter shot first, then boost feedback
  smk_meas_t ms, next_ms;
  logic       photo_req, next_photo_req, boost_req, next_boost_req;
  logic [7:0] settle, next_settle, duty, next_duty, pwm_cnt;
  logic       next_adc_start, next_adc_sel, next_emitter;
  logic [9:0] next_photo;

  always_comb begin
    next_ms        = ms;
    next_settle    = settle;
    next_duty      = duty;
    next_adc_start = 1'b0;
    next_adc_sel   = adc_sel_boost;
    next_emitter   = emitter_enable;
    next_photo     = photo_reading;
    smoke_seen     = 1'b0;
    next_photo_req = photo_req | emit_evt;
    next_boost_req = boost_req | (tick & boost_enable);
    case (ms)
      SMK_MS_IDLE: begin
        if (photo_req) begin
          next_photo_req = emit_evt;
          next_emitter   = 1'b1;
          next_settle    = 8'h00;
          next_ms        = SMK_MS_SETTLE;
        end else if (boost_req) begin
          next_boost_req = tick & boost_enable;
          if (boost_enable) begin
            next_adc_start = 1'b1;
            next_adc_sel   = 1'b1;
            next_ms        = SMK_MS_BOOST;
          end
        end
      end
      SMK_MS_SETTLE: begin
        next_settle = settle + 8'h01;
        if (settle == 8'(`SMK_SETTLE_CYCLES - 1)) begin
          next_adc_start = 1'b1;
          next_adc_sel   = 1'b0;
          next_ms        = SMK_MS_PHOTO;
        end
      end
      SMK_MS_PHOTO: begin
        if (adc_done) begin
          next_photo   = adc_data;
          next_emitter = 1'b0;
          smoke_seen   = (adc_data >= `SMK_SMOKE_THRESH);
          next_ms      = SMK_MS_IDLE;
        end
      end
      default: begin
        if (adc_done) begin
          next_ms = SMK_MS_IDLE;
          if (adc_data < `SMK_BOOST_TARGET && duty < `SMK_DUTY_MAX)
            next_duty = duty + 8'h01;
          else if (adc_data > `SMK_BOOST_TARGET && duty != 8'h00)
            next_duty = duty - 8'h01;
        end
      end
    endcase
    if (!boost_enable) next_duty = 8'h00;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ms             <= SMK_MS_IDLE;
      photo_req      <= 1'b0;
      boost_req      <= 1'b0;
      settle         <= 8'h00;
      duty           <= 8'h00;
      pwm_cnt        <= 8'h00;
      adc_start      <= 1'b0;
      adc_sel_boost  <= 1'b0;
      emitter_enable <= 1'b0;
      photo_reading  <= 10'h000;
      boost_pwm      <= 1'b0;
    end else begin
      ms             <= next_ms;
      photo_req      <= next_photo_req;
      boost_req      <= next_boost_req;
      settle         <= next_settle;
      duty           <= next_duty;
      pwm_cnt        <= pwm_cnt + 8'h01;
      adc_start      <= next_adc_start;
      adc_sel_boost  <= next_adc_sel;
      emitter_enable <= next_emitter;
      photo_reading  <= next_photo;
      boost_pwm      <= boost_enable & (pwm_cnt < duty);
    end
  end

  // Front-end register traffic
  smk_seq_t sq, next_sq;
  logic       sent, next_sent, batt_pend, next_batt_pend, led_pend, next_led_pend;
  logic       next_start, next_rw, next_bvalid;
  logic [4:0] next_addr;
  logic [7:0] next_wdata, next_batt;

  // One frame per step; a step moves on only when its frame is done
  always_comb begin
    next_sq        = sq;
    next_sent      = sent;
    next_start     = 1'b0;
    next_rw        = `SMK_SPI_WRITE;
    next_addr      = spi.addr;
    next_wdata     = spi.wdata;
    next_batt      = battery_reading;
    next_bvalid    = 1'b0;
    next_batt_pend = batt_pend | batt_test_req;
    next_led_pend  = led_pend | led_code_update;
    case (sq)
      SMK_SQ_LED: begin
        next_addr  = `SMK_REG_LED_CURRENT;
        next_wdata = led_current_code;
      end
      SMK_SQ_LOAD_ON: begin
        next_addr  = `SMK_REG_BATT_LOAD;
        next_wdata = `SMK_BATT_LOAD_ON;
      end
      SMK_SQ_READ: begin
        next_addr  = `SMK_REG_BATT_CURR;
        next_rw    = `SMK_SPI_READ;
        next_wdata = 8'h00;
      end
      SMK_SQ_LOAD_OFF: begin
        next_addr  = `SMK_REG_BATT_LOAD;
        next_wdata = `SMK_BATT_LOAD_OFF;
      end
      default: begin
        if (led_pend) begin
          next_sq       = SMK_SQ_LED;
          next_led_pend = led_code_update;
        end else if (batt_pend) begin
          next_sq        = SMK_SQ_LOAD_ON;
          next_batt_pend = batt_test_req;
        end
      end
    endcase
    if (sq != SMK_SQ_IDLE) begin
      if (!sent && !spi.busy && !spi.start) begin
        next_start = 1'b1;
        next_sent  = 1'b1;
      end else if (spi.done) begin
        next_sent = 1'b0;
        case (sq)
          SMK_SQ_LOAD_ON: next_sq = SMK_SQ_READ;
          SMK_SQ_READ: begin
            next_batt   = spi.rdata;
            next_bvalid = 1'b1;
            next_sq     = SMK_SQ_LOAD_OFF;
          end
          default: next_sq = SMK_SQ_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sq              <= SMK_SQ_LED;
      sent            <= 1'b0;
      batt_pend       <= 1'b0;
      led_pend        <= 1'b0;
      spi.start       <= 1'b0;
      spi.rw          <= `SMK_SPI_WRITE;
      spi.addr        <= 5'h00;
      spi.wdata       <= 8'h00;
      battery_reading <= 8'h00;
      battery_valid   <= 1'b0;
    end else begin
      sq              <= next_sq;
      sent            <= next_sent;
      batt_pend       <= next_batt_pend;
      led_pend        <= next_led_pend;
      spi.start       <= next_start;
      spi.rw          <= next_rw;
      spi.addr        <= next_addr;
      spi.wdata       <= next_wdata;
      battery_reading <= next_batt;
      battery_valid   <= next_bvalid;
    end
  end

  smk_spi_engine u_spi (
    .mclk      (mclk),
    .reset     (reset),
    .req       (spi.engine),
    .spi_sck   (spi_sck),
    .spi_mosi  (spi_mosi),
    .spi_sen_n (spi_sen_n),
    .spi_miso  (spi_miso)
  );
endmodule

// [smk_afe_model.sv]
`include "smk_consts.svh"

module smk_afe_model
  import smk_pkg::*;
(
  // Clock
  input  wire logic       mclk,
  // Converter
  input  wire logic       adc_start,
  input  wire logic       adc_sel_boost,
  output logic            adc_done,
  output logic [9:0]      adc_data,
  // Scene set by the bench
  input  wire logic [7:0] adc_delay,
  input  wire logic [9:0] photo_level,
  input  wire logic [9:0] boost_level,
  input  wire logic [7:0] batt_current,
  // SPI pins
  input  wire logic       spi_sck,
  input  wire logic       spi_mosi,
  input  wire logic       spi_sen_n,
  output logic            spi_miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  regs [0:30];
  logic [15:0] shift;
  logic [7:0]  miso_sh;
  logic        sel;
  int          bit_cnt;
  int          wait_n;

  // Power-up state of the front end
  initial begin
    for (int i = 0; i < 31; i++) regs[i] = 8'h00;
    adc_done = 1'b0;
    adc_data = 10'h155;
    miso_sh = 8'h00;
    wait_n = 0;
    bit_cnt = 0;
  end

  // Converter: data toggles outside done so stale values never look valid
  always @(posedge mclk) begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (wait_n > 0) begin
      wait_n = wait_n - 1;
      if (wait_n == 0) begin
        adc_done <= 1'b1;
        adc_data <= sel ? boost_level : photo_level;
      end
    end else if (adc_start) begin
      wait_n = int'(adc_delay);
      sel = adc_sel_boost;
    end
  end

  // Frame start
  always @(negedge spi_sen_n) bit_cnt = 0;

  // Mode 0 receive, MSB first; writes land after the 16th bit
  always @(posedge spi_sck) begin
    if (!spi_sen_n) begin
      shift = {shift[14:0], spi_mosi};
      bit_cnt = bit_cnt + 1;
      if (bit_cnt == 16 && shift[15] && shift[14:10] < 5'h1f) begin
        regs[shift[14:10]] = shift[7:0];
        if (shift[14:10] == `SMK_REG_BATT_LOAD) begin
          regs[`SMK_REG_BATT_CURR] = (shift[7:0] == `SMK_BATT_LOAD_ON) ?
                                     batt_current : 8'h00;
        end
      end
    end
  end

  // Read data shifts out on falling edges once the address is known
  always @(negedge spi_sck) begin
    if (!spi_sen_n) begin
      miso_sh = (bit_cnt == 8) ? regs[shift[6:2]] : {miso_sh[6:0], ~miso_sh[7]};
    end
  end

  // No pull on the line: deselected shows the inverse of the last bit
  assign spi_miso = spi_sen_n ? ~miso_sh[7] : miso_sh[7];
endmodule

// [smk_seq_checker.sv]
module smk_seq_checker
  import smk_pkg::*;
#(
  parameter int TICK_CYCLES = 20
)(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Board input and converter
  input wire logic test_button,
  input wire logic adc_start,
  input wire logic adc_sel_boost,
  input wire logic adc_done,
  // Indicators and boost
  input wire logic alarm_indicator,
  input wire logic horn_enable,
  input wire logic emitter_enable,
  input wire logic boost_enable,
  input wire logic boost_bypass,
  input wire logic boost_pwm,
  input wire logic smoke_alarm,
  // SPI
  input wire logic spi_sck,
  input wire logic spi_sen_n
);
  // Loose bound: a photo shot may delay one boost sample
  localparam int GAP_MAX = 2 * TICK_CYCLES + 400;
  logic        sck_q;
  logic        pend;
  logic [7:0]  sck_run;
  logic [15:0] boost_gap;
  logic [15:0] emit_run;

  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  // Run lengths and outstanding conversion
  always_ff @(posedge mclk) begin
    if (reset) begin
      sck_q <= 1'b0;
      sck_run <= 8'hff;
      pend <= 1'b0;
      boost_gap <= 16'h0000;
      emit_run <= 16'h0000;
    end else begin
      sck_q <= spi_sck;
      sck_run <= (spi_sck != sck_q) ? 8'h01 : ((sck_run == 8'hff) ? sck_run : sck_run + 8'h01);
      pend <= adc_start ? 1'b1 : (adc_done ? 1'b0 : pend);
      boost_gap <= (!boost_enable || (adc_start && adc_sel_boost)) ? 16'h0000
                 : boost_gap + 16'h0001;
      emit_run <= emitter_enable ? emit_run + 16'h0001 : 16'h0000;
    end
  end

  a_alarm_follows_horn: assert property (alarm_indicator == horn_enable)
    else $error("alarm indicator differs from horn");
  a_boost_needs_horn: assert property (boost_enable |-> horn_enable)
    else $error("boost on without horn");
  a_pwm_idle_off: assert property (!boost_enable && !$past(boost_enable)
    && !$past(boost_enable, 2) |-> !boost_pwm)
    else $error("pwm active with boost off");
  a_bypass_no_boost: assert property (boost_bypass |-> !boost_enable)
    else $error("boost enabled while bypassed");
  a_sck_half_period: assert property (spi_sck != sck_q |-> sck_run >= 8'h20)
    else $error("spi clock phase too short");
  a_sck_idle_low: assert property (spi_sen_n |-> !spi_sck)
    else $error("spi clock moves while deselected");
  a_one_conversion: assert property (adc_start |-> !pend)
    else $error("conversion started while one is pending");
  a_boost_loop_paced: assert property (int'(boost_gap) <= GAP_MAX)
    else $error("boost loop sample overdue");
  a_settle_before_photo: assert property (adc_start && !adc_sel_boost
    |-> emit_run >= 16'h00fa)
    else $error("photo conversion without emitter settle");
  a_test_horn_starts: assert property ($rose(test_button) && !horn_enable
    |-> ##[1:3] horn_enable)
    else $error("button did not start horn test");
  a_smoke_holds_horn: assert property (smoke_alarm |-> horn_enable)
    else $error("horn off during smoke alarm");
  a_press_silences: assert property ($rose(test_button) && smoke_alarm
    |-> ##[1:4] !smoke_alarm)
    else $error("button did not silence smoke alarm");
endmodule

bind smk_seq smk_seq_checker #(.TICK_CYCLES(TICK_CYCLES)) u_checker (
  .mclk(mclk), .reset(reset), .test_button(test_button), .adc_start(adc_start),
  .adc_sel_boost(adc_sel_boost), .adc_done(adc_done), .alarm_indicator(alarm_indicator),
  .horn_enable(horn_enable), .emitter_enable(emitter_enable), .boost_enable(boost_enable),
  .boost_bypass(boost_bypass), .boost_pwm(boost_pwm), .smoke_alarm(smoke_alarm),
  .spi_sck(spi_sck), .spi_sen_n(spi_sen_n)
);

// [test_smoke_alarm_sequencer.sv]
`include "smk_consts.svh"

module test_smoke_alarm_sequencer
  import smk_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Short tick keeps the ten-second shot inside the run
  localparam int TICK = 4;
  logic       mclk, reset, test_button, supply_is_9v, led_code_update, batt_test_req;
  logic [7:0] led_current_code, adc_delay, batt_current, battery_reading;
  logic [9:0] photo_level, boost_level, adc_data, photo_reading;
  logic       adc_start, adc_sel_boost, adc_done, alarm_indicator, presence_indicator;
  logic       horn_enable, emitter_enable, boost_enable, boost_bypass, boost_pwm;
  logic       smoke_alarm, battery_valid, spi_sck, spi_mosi, spi_sen_n, spi_miso;
  int         err_count, tests_run, since_rst;

  smk_seq #(.TICK_CYCLES(TICK)) DUT (
    .mclk(mclk), .reset(reset), .test_button(test_button), .supply_is_9v(supply_is_9v),
    .led_current_code(led_current_code), .led_code_update(led_code_update),
    .batt_test_req(batt_test_req), .adc_start(adc_start), .adc_sel_boost(adc_sel_boost),
    .adc_done(adc_done), .adc_data(adc_data), .alarm_indicator(alarm_indicator),
    .presence_indicator(presence_indicator), .horn_enable(horn_enable),
    .emitter_enable(emitter_enable), .boost_enable(boost_enable), .boost_bypass(boost_bypass),
    .boost_pwm(boost_pwm), .smoke_alarm(smoke_alarm), .photo_reading(photo_reading),
    .battery_reading(battery_reading), .battery_valid(battery_valid), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_sen_n(spi_sen_n), .spi_miso(spi_miso));

  smk_afe_model model (
    .mclk(mclk), .adc_start(adc_start), .adc_sel_boost(adc_sel_boost), .adc_done(adc_done),
    .adc_data(adc_data), .adc_delay(adc_delay), .photo_level(photo_level),
    .boost_level(boost_level), .batt_current(batt_current), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_sen_n(spi_sen_n), .spi_miso(spi_miso));

  // Clock and time since reset release
  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) since_rst <= reset ? 0 : since_rst + 1;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (err_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Bounded wait; counts edges until the level is seen
  task automatic wait_sig(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask

  task automatic wait_reg(input logic [4:0] a, input logic [7:0] v);
    int n;
    n = 0;
    while (model.regs[a] !== v && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    check("afe_register", model.regs[a], v);
  endtask

  task automatic sc_blink();
    int n;
    wait_sig(presence_indicator, !presence_indicator, 3000 * TICK, n);
    wait_sig(presence_indicator, !presence_indicator, 3000 * TICK, n);
    check("blink_half_period", n, 1000 * TICK);
  endtask

  // Timed test, a second press half a second in must not stretch it
  task automatic sc_test();
    int n, hi, pwm_hi, iters;
    @(posedge mclk) test_button <= 1'b1;
    wait_sig(horn_enable, 1'b1, 6, n);
    check("test_horn_on", horn_enable, 1'b1);
    hi = 0;
    pwm_hi = 0;
    iters = 0;
    while (horn_enable === 1'b1 && hi < 7000 * TICK) begin
      @(posedge mclk);
      hi++;
      if (hi == 8 || hi == 1000 * TICK + 8) test_button <= 1'b0;
      if (hi == 1000 * TICK) test_button <= 1'b1;
      if (adc_start === 1'b1 && adc_sel_boost === 1'b1) iters++;
      if (hi >= 5000 * TICK && hi < 5000 * TICK + 256 && boost_pwm === 1'b1) pwm_hi++;
    end
    check("test_length_ok", hi >= 5999 * TICK && hi <= 6001 * TICK, 1'b1);
    check("boost_loop_count_ok", iters >= 5990 && iters <= 6001, 1'b1);
    check("pwm_high_cycles", pwm_hi, 32'(`SMK_DUTY_MAX));
    check("boost_off_after", boost_enable, 1'b0);
  endtask

  task automatic sc_battery();
    int n;
    @(posedge mclk) batt_test_req <= 1'b1;
    @(posedge mclk) batt_test_req <= 1'b0;
    wait_sig(battery_valid, 1'b1, 4000, n);
    check("battery_valid", battery_valid, 1'b1);
    check("battery_reading", battery_reading, batt_current);
    wait_reg(`SMK_REG_BATT_LOAD, `SMK_BATT_LOAD_OFF);
  endtask

  task automatic sc_led_update();
    @(posedge mclk) led_current_code <= 8'ha5;
    led_code_update <= 1'b1;
    @(posedge mclk) led_code_update <= 1'b0;
    wait_reg(`SMK_REG_LED_CURRENT, 8'ha5);
  endtask

  // Boundary reading raises smoke on a 9 V supply; a press silences it
  task automatic sc_smoke();
    int n;
    photo_level <= `SMK_SMOKE_THRESH;
    adc_delay <= 8'h28;
    supply_is_9v <= 1'b1;
    wait_sig(emitter_enable, 1'b1, 60000, n);
    check("shot_time", since_rst >= 19998 * TICK && since_rst <= 20002 * TICK, 1'b1);
    wait_sig(smoke_alarm, 1'b1, 600, n);
    repeat (40) @(posedge mclk);
    check("photo_reading", photo_reading, `SMK_SMOKE_THRESH);
    check("emitter_off", emitter_enable, 1'b0);
    check("smoke_horn", horn_enable, 1'b1);
    check("boost_on_9v", boost_enable, 1'b0);
    check("bypass_on_9v", boost_bypass, 1'b1);
    test_button <= 1'b1;
    repeat (6) @(posedge mclk);
    check("silenced", {horn_enable, smoke_alarm}, 2'b00);
    test_button <= 1'b0;
  endtask

  task automatic sc_reset_mid();
    int n;
    supply_is_9v <= 1'b0;
    repeat (4) @(posedge mclk);
    test_button <= 1'b1;
    wait_sig(boost_enable, 1'b1, 8, n);
    reset <= 1'b1;
    test_button <= 1'b0;
    led_current_code <= 8'h5c;
    repeat (3) @(posedge mclk);
    check("reset_outputs", {horn_enable, alarm_indicator, boost_enable, boost_pwm,
          presence_indicator, smoke_alarm, emitter_enable, spi_sen_n}, 8'h01);
    reset <= 1'b0;
    wait_reg(`SMK_REG_LED_CURRENT, 8'h5c);
    check("horn_after_reset", horn_enable, 1'b0);
  endtask

  // Main sequence
  initial begin
    reset = 1'b1;
    test_button = 1'b0;
    supply_is_9v = 1'b0;
    led_current_code = 8'h3c;
    led_code_update = 1'b0;
    batt_test_req = 1'b0;
    adc_delay = 8'h01; // Fast converter so one boost sample fits each short tick
    photo_level = 10'h040;
    boost_level = 10'h100;
    batt_current = 8'h6b;
    err_count = 0;
    tests_run = 0;
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    wait_reg(`SMK_REG_LED_CURRENT, 8'h3c);
    sc_blink();
    sc_test();
    sc_battery();
    sc_led_update();
    sc_smoke();
    sc_reset_mid();
    finish_test();
  end

  // Watchdog, well past the expected run length
  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    finish_test();
  end
endmodule
